/* common/cpr_defs.svh */
// Purpose: Offsets, field positions, reset values of the collision and page registers.
// Assumes: Six-bit register addresses and eight-bit data.
// Notes:   Definitions only.
`ifndef CPR_DEFS_SVH
`define CPR_DEFS_SVH
`define CPR_ADDR_COLLISION_STATUS  6'h0E
`define CPR_ADDR_PAGE_SELECT       6'h10
`define CPR_ADDR_MODE_CONFIG       6'h11
`define CPR_RESET_PAGE_SELECT      8'h00
`define CPR_RESET_MODE_CONFIG      8'h3B
`define CPR_COLL_KEEP_BIT          7
`define CPR_COLL_INVALID_BIT       5
`define CPR_PAGE_OVERRIDE_BIT      7
`define CPR_POS_MAX                6'h20
`endif

/* common/cpr_pkg.sv */
// Purpose: Types shared by the collision and page register bank.
// Assumes: Nothing beyond the defs header.
// Notes:   Types only.
`default_nettype none
package cpr_pkg;
    typedef enum logic [1:0] {
        CPR_IDLE = 2'h0,
        CPR_RECV = 2'h1,
        CPR_DONE = 2'h3
    } cpr_state_type;

    typedef struct packed {
        cpr_state_type state;
        logic          keep_bits_after_collision;
        logic          collision_position_invalid;
        logic          collision_seen;
        logic [4:0]    first_collision_position;
        logic [5:0]    bit_count;
        logic          page_override_enable;
        logic [1:0]    page_number;
        logic [7:0]    mode_config;
        logic [7:0]    rdata;
        logic [5:0]    reg_addr;
        logic          rx_bit;
        logic          rx_bit_valid;
    } cpr_regs_type;
endpackage
`default_nettype wire

/* core/cpr_collision_page_regs.sv */
// Purpose: Collision status, register page and mode configuration registers.
// Assumes: Host accesses and receiver strobes are synchronous to mclk_in.
// Notes:   Read data is registered and appears one cycle after rd_en_in.
//
// Summary of operation
// - Keep bit zero clears every received data bit after the first collision.
// - Invalid flag set when no collision seen or position out of range.
// - Read-only five-bit field holds first collision position, data bits only.
// - Position 01h is first bit, 08h eighth, 00h thirty-second.
// - Collision status at 0Eh resets to 101XXXXXb; only bit 7 writable.
// - Page override set makes page number supply address bits A5 and A4.
// - Page override clear takes the whole address from the latch.
// - Page number in bits 1 to 0, ignored unless override is set.
// - Page register at 10h resets to 00h; bits 6 to 2 read zero.
// - Mode configuration at 11h resets to 3Bh, fully read and write.
`include "cpr_defs.svh"
`default_nettype none
module cpr_collision_page_regs (
    input  wire logic       mclk_in,
    input  wire logic       arst_n_in,
    input  wire logic [5:0] addr_latch_in,
    input  wire logic [3:0] addr_pins_in,
    input  wire logic       wr_en_in,
    input  wire logic       rd_en_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       rx_start_in,
    input  wire logic       rx_end_in,
    input  wire logic       rx_bit_valid_in,
    input  wire logic       rx_bit_in,
    input  wire logic       rx_collision_in,
    output var  logic [7:0] rdata_out,
    output var  logic [5:0] reg_addr_out,
    output var  logic       rx_bit_out,
    output var  logic       rx_bit_valid_out,
    output var  logic [7:0] mode_config_out
);
    cpr_pkg::cpr_regs_type r_reg;
    cpr_pkg::cpr_regs_type r_next;
    logic [5:0]            addr_comb;
    logic                  collided;

    // ****************************************
    // Address forming
    // ****************************************
    always_comb begin
        if (r_reg.page_override_enable) begin
            addr_comb = {r_reg.page_number, addr_pins_in};
        end else begin
            addr_comb = addr_latch_in;
        end
    end

    // A collision already recorded in this frame means the position is held.
    // The seen flag is kept apart from the invalid flag: a collision beyond the
    // representable range leaves the position invalid but must still clear later bits.
    assign collided = (r_reg.state == cpr_pkg::CPR_RECV) && r_reg.collision_seen;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        r_next = r_reg;
        r_next.reg_addr = addr_comb;
        r_next.rx_bit_valid = 1'b0;
        if (wr_en_in && addr_comb == `CPR_ADDR_MODE_CONFIG) begin
            r_next.mode_config = wdata_in;
        end
        if (wr_en_in && addr_comb == `CPR_ADDR_PAGE_SELECT) begin
            r_next.page_override_enable = wdata_in[`CPR_PAGE_OVERRIDE_BIT];
            r_next.page_number = wdata_in[1:0];
        end
        if (wr_en_in && addr_comb == `CPR_ADDR_COLLISION_STATUS) begin
            r_next.keep_bits_after_collision = wdata_in[`CPR_COLL_KEEP_BIT];
        end
        unique case (r_reg.state)
            cpr_pkg::CPR_IDLE,
            cpr_pkg::CPR_DONE: begin
                if (rx_start_in) begin
                    r_next.state = cpr_pkg::CPR_RECV;
                    r_next.collision_position_invalid = 1'b1;
                    r_next.collision_seen = 1'b0;
                    r_next.first_collision_position = 5'h00;
                    r_next.bit_count = 6'h00;
                end
            end
            cpr_pkg::CPR_RECV: begin
                if (rx_bit_valid_in) begin
                    r_next.rx_bit_valid = 1'b1;
                    r_next.rx_bit = rx_bit_in;
                    if (r_reg.bit_count != 6'h3F) begin
                        r_next.bit_count = r_reg.bit_count + 6'h01;
                    end
                    if (collided && !r_reg.keep_bits_after_collision) begin
                        r_next.rx_bit = 1'b0;
                    end
                    if (rx_collision_in && !r_reg.collision_seen) begin
                        r_next.collision_seen = 1'b1;
                        if (r_reg.bit_count < `CPR_POS_MAX) begin
                            r_next.collision_position_invalid = 1'b0;
                            r_next.first_collision_position = 5'(r_reg.bit_count + 6'h01);
                        end
                    end
                end
                if (rx_end_in) begin
                    r_next.state = cpr_pkg::CPR_DONE;
                end
            end
            default: begin
                r_next.state = cpr_pkg::CPR_IDLE;
            end
        endcase
        if (rd_en_in) begin
            unique case (addr_comb)
                `CPR_ADDR_COLLISION_STATUS:
                    r_next.rdata = {r_reg.keep_bits_after_collision, 1'b0,
                                    r_reg.collision_position_invalid,
                                    r_reg.first_collision_position};
                `CPR_ADDR_PAGE_SELECT:
                    r_next.rdata = {r_reg.page_override_enable, 5'h00, r_reg.page_number};
                `CPR_ADDR_MODE_CONFIG:
                    r_next.rdata = r_reg.mode_config;
                default:
                    r_next.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            r_reg.state <= cpr_pkg::CPR_IDLE;
            r_reg.keep_bits_after_collision <= 1'b1;
            r_reg.collision_position_invalid <= 1'b1;
            r_reg.collision_seen <= 1'b0;
            r_reg.first_collision_position <= 5'h00;
            r_reg.bit_count <= 6'h00;
            {r_reg.page_override_enable, r_reg.page_number} <= 3'h0;
            r_reg.mode_config <= `CPR_RESET_MODE_CONFIG;
            r_reg.rdata <= 8'h00;
            r_reg.reg_addr <= 6'h00;
            r_reg.rx_bit <= 1'b0;
            r_reg.rx_bit_valid <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rdata_out = r_reg.rdata;
    assign reg_addr_out = r_reg.reg_addr;
    assign rx_bit_out = r_reg.rx_bit;
    assign rx_bit_valid_out = r_reg.rx_bit_valid;
    assign mode_config_out = r_reg.mode_config;

    // ****************************************
    // Assertions
    // ****************************************
    property p_clear_after_coll;
        @(posedge mclk_in) disable iff (!arst_n_in)
        (collided && !r_reg.keep_bits_after_collision && rx_bit_valid_in)
            |=> (rx_bit_valid_out && !rx_bit_out);
    endproperty
    a_clear_after_coll: assert property (p_clear_after_coll)
        else $error("bit after collision not cleared");

    property p_invalid_on_start;
        @(posedge mclk_in) disable iff (!arst_n_in)
        (r_reg.state != cpr_pkg::CPR_RECV && rx_start_in)
            |=> r_reg.collision_position_invalid;
    endproperty
    a_invalid_on_start: assert property (p_invalid_on_start)
        else $error("invalid flag not set at reception start");

    property p_pos_encode;
        @(posedge mclk_in) disable iff (!arst_n_in)
        (r_reg.state == cpr_pkg::CPR_RECV && rx_bit_valid_in && rx_collision_in
         && r_reg.collision_position_invalid && r_reg.bit_count < 6'h20)
            |=> (r_reg.first_collision_position == 5'($past(r_reg.bit_count) + 6'h01))
                && !r_reg.collision_position_invalid;
    endproperty
    a_pos_encode: assert property (p_pos_encode)
        else $error("collision position wrongly encoded");

    property p_out_of_range;
        @(posedge mclk_in) disable iff (!arst_n_in)
        (r_reg.state == cpr_pkg::CPR_RECV && r_reg.collision_position_invalid
         && r_reg.bit_count >= 6'h20 && !rx_start_in) |=> r_reg.collision_position_invalid;
    endproperty
    a_out_of_range: assert property (p_out_of_range)
        else $error("out of range collision marked valid");

    property p_first_only;
        @(posedge mclk_in) disable iff (!arst_n_in)
        (collided && !rx_end_in) |=> $stable(r_reg.first_collision_position);
    endproperty
    a_first_only: assert property (p_first_only)
        else $error("later collision overwrote position");

    property p_page_addr;
        @(posedge mclk_in) disable iff (!arst_n_in)
        r_reg.page_override_enable
            |=> reg_addr_out == {$past(r_reg.page_number), $past(addr_pins_in)};
    endproperty
    a_page_addr: assert property (p_page_addr)
        else $error("page number not used as A5 A4");

    property p_latch_addr;
        @(posedge mclk_in) disable iff (!arst_n_in)
        !r_reg.page_override_enable |=> reg_addr_out == $past(addr_latch_in);
    endproperty
    a_latch_addr: assert property (p_latch_addr)
        else $error("latch address not used");

    property p_page_read;
        @(posedge mclk_in) disable iff (!arst_n_in)
        (rd_en_in && addr_comb == `CPR_ADDR_PAGE_SELECT) |=> rdata_out[6:2] == 5'h00;
    endproperty
    a_page_read: assert property (p_page_read)
        else $error("page reserved bits not zero");

    property p_coll_ro;
        @(posedge mclk_in) disable iff (!arst_n_in)
        (wr_en_in && addr_comb == `CPR_ADDR_COLLISION_STATUS && r_reg.state == cpr_pkg::CPR_DONE
         && !rx_start_in) |=> $stable(r_reg.first_collision_position);
    endproperty
    a_coll_ro: assert property (p_coll_ro)
        else $error("read-only field changed by write");

    property p_mode_rw;
        @(posedge mclk_in) disable iff (!arst_n_in)
        (wr_en_in && addr_comb == `CPR_ADDR_MODE_CONFIG) |=> mode_config_out == $past(wdata_in);
    endproperty
    a_mode_rw: assert property (p_mode_rw)
        else $error("mode config write lost");

    property p_mode_read;
        @(posedge mclk_in) disable iff (!arst_n_in)
        (rd_en_in && addr_comb == `CPR_ADDR_MODE_CONFIG)
            |=> rdata_out == $past(r_reg.mode_config);
    endproperty
    a_mode_read: assert property (p_mode_read)
        else $error("mode config read wrong");

    property p_none_invalid;
        @(posedge mclk_in) disable iff (!arst_n_in)
        !r_reg.collision_seen |-> r_reg.collision_position_invalid;
    endproperty
    a_none_invalid: assert property (p_none_invalid)
        else $error("invalid flag clear without a collision");

    property p_keep_write;
        @(posedge mclk_in) disable iff (!arst_n_in)
        (wr_en_in && addr_comb == `CPR_ADDR_COLLISION_STATUS)
            |=> r_reg.keep_bits_after_collision == $past(wdata_in[7]);
    endproperty
    a_keep_write: assert property (p_keep_write)
        else $error("keep bit write lost");

    property p_page_write;
        @(posedge mclk_in) disable iff (!arst_n_in)
        (wr_en_in && addr_comb == `CPR_ADDR_PAGE_SELECT)
            |=> {r_reg.page_override_enable, r_reg.page_number}
                == {$past(wdata_in[7]), $past(wdata_in[1:0])};
    endproperty
    a_page_write: assert property (p_page_write)
        else $error("page register write lost");

    property p_coll_read;
        @(posedge mclk_in) disable iff (!arst_n_in)
        (rd_en_in && addr_comb == `CPR_ADDR_COLLISION_STATUS)
            |=> rdata_out == {$past(r_reg.keep_bits_after_collision), 1'b0,
                              $past(r_reg.collision_position_invalid),
                              $past(r_reg.first_collision_position)};
    endproperty
    a_coll_read: assert property (p_coll_read)
        else $error("collision status read wrong");

    c_collision: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
        $fell(r_reg.collision_position_invalid));
    c_page_on: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
        $rose(r_reg.page_override_enable));
    c_frame_done: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
        r_reg.state == cpr_pkg::CPR_DONE);
    c_far_collision: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
        r_reg.collision_seen && r_reg.collision_position_invalid);
    c_bit_cleared: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
        collided && !r_reg.keep_bits_after_collision && rx_bit_valid_in);
endmodule
`default_nettype wire

/* verification/cpr_host_model.sv */
// Purpose: Host model that reaches the register bank through its address paths.
// Assumes: Strobes are taken on the rising edge of mclk_in.
// Notes:   Queues the expected read results for the bench monitor.
`default_nettype none
module cpr_host_model (
    input  wire logic       mclk_in,
    output var  logic [5:0] addr_latch_out,
    output var  logic [3:0] addr_pins_out,
    output var  logic       wr_en_out,
    output var  logic       rd_en_out,
    output var  logic [7:0] wdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [13:0] rd_q[$];
    logic        ovr = 1'b0;
    logic [1:0]  page = 2'h0;
    initial begin
        {addr_latch_out, addr_pins_out, wr_en_out, rd_en_out, wdata_out} = '0;
    end
    // The unused address path carries the inverse, so a wrong path choice shows.
    // address path
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
                       input logic [7:0] e);
        @(posedge mclk_in);
        addr_latch_out <= ovr ? ~a : a;
        addr_pins_out <= ovr ? a[3:0] : ~a[3:0];
        wr_en_out <= w;
        rd_en_out <= !w;
        wdata_out <= d;
        if (!w) rd_q.push_back({ovr ? {page, a[3:0]} : a, e});
        if (w && a == 6'h10) {ovr, page} = {d[7], d[1:0]};
        @(posedge mclk_in);
        wr_en_out <= 1'b0;
        rd_en_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* verification/collision_and_page_registers_tb_top.sv */
// Purpose: Self-checking bench for the collision and page register bank.
// Assumes: Read data and received bits appear one cycle after their strobes.
// Notes:   Driver processes queue expectations; a monitor compares them.
`default_nettype none
module collision_and_page_registers_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk = 1'b0, arst_n = 1'b0, rd_seen = 1'b0;
    logic       rx_start = 1'b0, rx_end = 1'b0, rx_v = 1'b0, rx_b = 1'b0, rx_c = 1'b0;
    logic [5:0] latch, ra;
    logic [3:0] pins;
    logic       wr_en, rd_en, rx_bo, rx_vo;
    logic [7:0] wdata, rdata, mode_cfg, d;
    logic       bit_q[$];
    int         fails = 0, n_compared = 0, cyc = 0, kt[6] = '{1, 8, 31, 32, 33, 0};
    int         seed = 32'heeaf6771;
    initial forever #50 mclk = ~mclk;
    cpr_host_model host (.mclk_in(mclk), .addr_latch_out(latch), .addr_pins_out(pins),
        .wr_en_out(wr_en), .rd_en_out(rd_en), .wdata_out(wdata));
    cpr_collision_page_regs uut (.mclk_in(mclk), .arst_n_in(arst_n), .addr_latch_in(latch),
        .addr_pins_in(pins), .wr_en_in(wr_en), .rd_en_in(rd_en), .wdata_in(wdata),
        .rx_start_in(rx_start), .rx_end_in(rx_end), .rx_bit_valid_in(rx_v),
        .rx_bit_in(rx_b), .rx_collision_in(rx_c), .rdata_out(rdata), .reg_addr_out(ra),
        .rx_bit_out(rx_bo), .rx_bit_valid_out(rx_vo), .mode_config_out(mode_cfg));
    // ****************************************
    // Checking
    // ****************************************
    task automatic chk_rd(input logic [13:0] got, input logic [13:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge mclk) rd_seen <= rd_en;
    always @(negedge mclk) begin
        if (rd_seen === 1'b1) chk_rd({ra, rdata}, host.rd_q.pop_front());
        if (rx_vo === 1'b1) chk_bit(rx_bo, bit_q.pop_front());
    end
    task automatic test_done();
        // A note left on a queue is a result that never appeared.
        if (bit_q.size() != 0 || host.rd_q.size() != 0) fails++;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            test_done();
        end
    end
    // ****************************************
    // Stimulus
    // ****************************************
    // A second collision three bits later must not replace the first one.
    task automatic rx_frame(input int k, input logic keep);
        logic b;
        logic inv;
        @(posedge mclk) rx_start <= 1'b1;
        @(posedge mclk) rx_start <= 1'b0;
        for (int i = 1; i <= 34; i++) begin
            @(posedge mclk);
            b = 1'($random(seed));
            rx_b <= b;
            rx_v <= 1'b1;
            rx_c <= (i == k) || (k > 0 && i == k + 3);
            bit_q.push_back((keep || k == 0 || i <= k) ? b : 1'b0);
        end
        @(posedge mclk);
        {rx_v, rx_c, rx_end} <= 3'h1;
        @(posedge mclk) rx_end <= 1'b0;
        inv = (k == 0 || k > 32);
        host.acc(1'b0, 6'h0E, 8'h00, {keep, 1'b0, inv, inv ? 5'h00 : 5'(k)});
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        chk_rd({6'h11, mode_cfg}, {6'h11, 8'h3B});
        host.acc(1'b0, 6'h0E, 8'h00, 8'hA0);
        host.acc(1'b0, 6'h10, 8'h00, 8'h00);
        host.acc(1'b0, 6'h11, 8'h00, 8'h3B);
        host.acc(1'b1, 6'h0E, 8'h7F, 8'h00);
        host.acc(1'b0, 6'h0E, 8'h00, 8'h20);
        // keep cleared only around anticollision frames
        for (int j = 0; j < 6; j++) begin
            host.acc(1'b1, 6'h0E, {j > 4, 7'h00}, 8'h00);
            rx_frame(kt[j], j > 4);
        end
        host.acc(1'b1, 6'h10, 8'h7E, 8'h00);
        host.acc(1'b0, 6'h10, 8'h00, 8'h02);
        d = 8'($random(seed));
        host.acc(1'b1, 6'h10, 8'h81, 8'h00);
        host.acc(1'b1, 6'h11, d, 8'h00);
        host.acc(1'b0, 6'h11, 8'h00, d);
        chk_rd({6'h11, mode_cfg}, {6'h11, d});
        host.acc(1'b0, 6'h10, 8'h00, 8'h81);
        host.acc(1'b1, 6'h10, 8'h03, 8'h00);
        host.acc(1'b0, 6'h11, 8'h00, d);
        host.acc(1'b1, 6'h12, 8'hFF, 8'h00);
        host.acc(1'b0, 6'h3F, 8'h00, 8'h00);
        host.acc(1'b0, 6'h11, 8'h00, d);
        host.acc(1'b0, 6'h0E, 8'h00, 8'hA0);
        repeat (3) @(posedge mclk);
        test_done();
    end
endmodule
`default_nettype wire
